//--- src/svm_top.sv
`timescale 1ns/10ps
`default_nettype none
module svm_top
   import svm_pkg::*;
#(
   parameter logic [31:0] TM_SECRET = 32'h5a5a_0001, // arbitrary value
   parameter logic [31:0] LOCK_TOP  = 32'h0000_1000,
   parameter logic [15:0] FREQ_MIN  = 16'h0010,
   parameter int          MIR_W     = 8
) (
   // clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst,
   // apb slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [7:0]        i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic                   o_pready,
   output logic [31:0]            o_prdata,
   output logic                   o_pslverr,
   // test mode and flash erase
   input  wire logic              i_flash_erase_done,
   output logic                   o_flash_erase_req,
   output logic                   o_engineering_test_mode,
   output logic                   o_loader_en,
   // detectors
   input  wire logic [MIR_W-1:0]  i_mirror_a,
   input  wire logic [MIR_W-1:0]  i_mirror_b,
   input  wire logic              i_rd_valid,
   input  wire logic [31:0]       i_rd_data,
   input  wire logic              i_rd_par,
   input  wire logic              i_freq_tick,
   input  wire logic              i_glitch,
   input  wire logic              i_cpu_lockup,
   // secure bridge access
   input  wire logic              i_br_valid,
   input  wire logic [1:0]        i_br_size,
   input  wire logic              i_br_fetch,
   input  wire logic              i_br_user,
   output logic                   o_br_done,
   output logic                   o_br_err,
   // mpu check
   input  wire logic              i_mpu_valid,
   input  wire logic [31:0]       i_mpu_addr,
   input  wire logic              i_mpu_write,
   input  wire logic              i_mpu_user,
   input  wire logic              i_mpu_fetch,
   output logic                   o_mpu_fault,
   output logic [3:0]             o_mpu_attr,
   // flash program and erase requests
   input  wire logic              i_fl_req,
   input  wire logic [31:0]       i_fl_addr,
   output logic                   o_fl_grant,
   output logic                   o_fl_reject,
   // reactions
   output logic                   o_irq,
   output logic                   o_nmi,
   output logic                   o_warm_rst,
   output logic                   o_cold_rst
);

   typedef struct packed {
      svm_tm_type            tm;
      logic [2:0]            ctrl;
      logic [N_EV-1:0]       status;
      logic [N_EV*3-1:0]     react;
      logic [31:0]           serial;
      logic [31:0]           prepers;
      logic [31:0]           crc;
      logic [N_RG-1:0][31:0] rg_base;
      logic [N_RG-1:0][21:0] rg_cfg;
      logic [15:0]           fcnt;
      logic                  lock_prev;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      logic                  br_done;
      logic                  br_err;
      logic                  mpu_fault;
      logic [3:0]            mpu_attr;
      logic                  fl_grant;
      logic                  fl_reject;
      logic                  irq;
      logic                  nmi;
      logic                  warm;
      logic                  cold;
   } svm_state_type;

   svm_state_type st_q;
   svm_state_type st_d;

   // one byte through the reflected crc, polynomial chosen by mode
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  b,
                                           input logic        m16);
      logic [31:0] r;
      logic [31:0] p;
      r = c ^ {24'h0, b};
      p = m16 ? P_CRC16 : P_CRC32;
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ p) : (r >> 1);
      end
      if (m16) begin
         r = {16'h0, r[15:0]};
      end
      return r;
   endfunction

   // highest numbered matching region wins, so overlaps are ordered
   function automatic logic [4:0] mpu_check(input svm_state_type s,
                                           input logic [31:0]   a,
                                           input logic          wr,
                                           input logic          usr,
                                           input logic          fx);
      logic        hit;
      logic        ok;
      logic [3:0]  at;
      logic [4:0]  sz;
      logic [2:0]  sub;
      logic [21:0] c;
      hit = 1'b0;
      ok  = 1'b1;
      at  = 4'h0;
      sz  = 5'h0;
      sub = 3'h0;
      c   = 22'h0;
      for (int i = 0; i < N_RG; i++) begin
         c   = s.rg_cfg[i];
         sz  = (c[R_SZ+:5] < 5'h8) ? 5'h8 : c[R_SZ+:5];
         sub = 3'((a >> (sz - 5'h3)) & 32'h7);
         if (c[R_EN] && ((a >> sz) == (s.rg_base[i] >> sz))
             && !c[R_SRD + 32'(sub)]) begin
            hit = 1'b1;
            at  = c[R_ATTR+:4];
            ok  = !(fx && c[R_XN]) &&
                  (usr ? (wr ? c[R_UW] : c[R_UR]) : (!wr || c[R_PW]));
         end
      end
      return {~(hit & ~ok), at};
   endfunction

   logic             acc;
   logic             wr_go;
   logic [N_EV-1:0]  ev;
   logic [2:0]       sev;
   logic [4:0]       mres;
   logic             br_bad;
   logic             fl_bad;
   logic             freq_bad;
   logic [3:0]       ridx;

   always_comb begin
      st_d     = st_q;
      acc      = i_psel & i_penable;
      wr_go    = acc & st_q.pready & i_pwrite & ~st_q.pslverr;
      ridx     = i_paddr[6:3];
      // bridge: only user rights, width and fetch
      br_bad   = i_br_valid & ((i_br_size != 2'h2) | i_br_fetch |
                               (i_br_user & ~st_q.ctrl[C_UAR]));
      mres     = mpu_check(st_q, i_mpu_addr, i_mpu_write,
                           i_mpu_user, i_mpu_fetch);
      fl_bad   = i_fl_req & st_q.ctrl[C_LOCK] &
                 (i_fl_addr < LOCK_TOP);
      // clock too fast counts above minimum per tick, slow falls short
      freq_bad = i_freq_tick & (st_q.fcnt < FREQ_MIN);
      ev             = '0;
      ev[EV_MIRROR]  = |(i_mirror_a ^ i_mirror_b);
      ev[EV_PARITY]  = i_rd_valid & ((^i_rd_data) != i_rd_par);
      ev[EV_BRIDGE]  = br_bad;
      ev[EV_MPU]     = i_mpu_valid & ~mres[4];
      ev[EV_FREQ]    = freq_bad;
      ev[EV_GLITCH]  = i_glitch;
      ev[EV_LOCKUP]  = i_cpu_lockup & ~st_q.lock_prev;
      ev[EV_FLASH]   = fl_bad;

      // frequency counter, saturating so the first tick is clean
      st_d.lock_prev = i_cpu_lockup;
      if (i_freq_tick) begin
         st_d.fcnt = 16'h0;
      end else if (st_q.fcnt != FREQ_SAT) begin
         st_d.fcnt = st_q.fcnt + 16'h1;
      end

      // access answers, registered one cycle after the request
      st_d.br_done   = i_br_valid & ~br_bad;
      st_d.br_err    = br_bad;
      st_d.mpu_fault = i_mpu_valid & ~mres[4];
      st_d.mpu_attr  = i_mpu_valid ? mres[3:0] : 4'h0;
      st_d.fl_grant  = i_fl_req & ~fl_bad;
      st_d.fl_reject = fl_bad;

      // strongest reaction among this cycle's events
      sev = RX_FLAG;
      for (int i = 0; i < N_EV; i++) begin
         if (ev[i] && st_q.react[i*3+:3] > sev &&
             st_q.react[i*3+:3] <= RX_COLD) begin
            sev = st_q.react[i*3+:3];
         end
      end
      st_d.irq  = |ev && (sev == RX_IRQ);
      st_d.nmi  = |ev && (sev == RX_NMI);
      st_d.warm = |ev && (sev == RX_WARM);
      st_d.cold = |ev && (sev == RX_COLD);

      // test mode sequencing
      case (st_q.tm)
         TM_IDLE: begin
            if (wr_go && i_paddr == A_TM_KEY && i_pwdata == TM_SECRET) begin
               st_d.tm = TM_ERASE;
            end
         end
         TM_ERASE: begin
            if (i_flash_erase_done) begin
               st_d.tm = TM_ACTIVE;
            end
         end
         TM_ACTIVE: begin
            st_d.tm = TM_ACTIVE;
         end
         default: begin
            st_d.tm = TM_IDLE;
         end
      endcase

      // apb: one wait state, data and error registered together with pready
      st_d.pready = acc & ~st_q.pready;
      if (acc && !st_q.pready) begin
         st_d.prdata  = 32'h0;
         st_d.pslverr = 1'b0;
         if (i_paddr[1:0] != 2'h0) begin
            st_d.pslverr = 1'b1;
         end else if (i_paddr == A_CTRL) begin
            st_d.prdata = {29'h0, st_q.ctrl};
         end else if (i_paddr == A_STATUS) begin
            st_d.prdata = {24'h0, st_q.status};
         end else if (i_paddr == A_REACT) begin
            st_d.prdata = {8'h0, st_q.react};
         end else if (i_paddr == A_TM_KEY) begin
            st_d.prdata = 32'h0;
         end else if (i_paddr == A_TM_STAT) begin
            st_d.prdata = {29'h0, st_q.tm};
         end else if (i_paddr == A_SERIAL || i_paddr == A_PREPERS) begin
            st_d.prdata  = (i_paddr == A_SERIAL) ? st_q.serial
                                                 : st_q.prepers;
            st_d.pslverr = i_pwrite & (st_q.tm != TM_ACTIVE);
         end else if (i_paddr == A_CRC || i_paddr == A_CRC_INI) begin
            st_d.prdata = st_q.crc;
         end else if (i_paddr >= A_RG_BASE && i_paddr <= A_RG_END) begin
            st_d.prdata = i_paddr[2] ? {10'h0, st_q.rg_cfg[ridx[2:0]]}
                                     : st_q.rg_base[ridx[2:0]];
         end else begin
            st_d.pslverr = 1'b1;
         end
      end

      // register writes at the completing edge
      if (wr_go) begin
         if (i_paddr == A_CTRL) begin
            st_d.ctrl = i_pwdata[2:0];
         end else if (i_paddr == A_REACT) begin
            st_d.react = i_pwdata[N_EV*3-1:0];
         end else if (i_paddr == A_SERIAL) begin
            st_d.serial = i_pwdata;
         end else if (i_paddr == A_PREPERS) begin
            st_d.prepers = i_pwdata;
         end else if (i_paddr == A_CRC) begin
            st_d.crc = crc_byte(st_q.crc, i_pwdata[7:0],
                                st_q.ctrl[C_C16]);
         end else if (i_paddr == A_CRC_INI) begin
            st_d.crc = st_q.ctrl[C_C16] ? {16'h0, CRC_SEED[15:0]}
                                        : CRC_SEED;
         end else if (i_paddr >= A_RG_BASE && i_paddr <= A_RG_END) begin
            if (i_paddr[2]) begin
               st_d.rg_cfg[ridx[2:0]] = i_pwdata[21:0];
            end else begin
               st_d.rg_base[ridx[2:0]] = i_pwdata;
            end
         end
      end

      // sticky status, write one to clear, a new event beats the clear
      if (wr_go && i_paddr == A_STATUS) begin
         st_d.status = (st_q.status & ~i_pwdata[N_EV-1:0]) | ev;
      end else begin
         st_d.status = st_q.status | ev;
      end
   end

   // single state register
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_q     <= '0;
         st_q.tm  <= TM_IDLE;
         st_q.crc <= CRC_SEED;
         st_q.fcnt <= FREQ_SAT;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign o_pready                = st_q.pready;
   assign o_prdata                = st_q.prdata;
   assign o_pslverr               = st_q.pslverr;
   assign o_flash_erase_req       = st_q.tm[1]; // one-hot erase bit
   assign o_engineering_test_mode = st_q.tm[2];
   assign o_loader_en             = st_q.tm[2];
   assign o_br_done               = st_q.br_done;
   assign o_br_err                = st_q.br_err;
   assign o_mpu_fault             = st_q.mpu_fault;
   assign o_mpu_attr              = st_q.mpu_attr;
   assign o_fl_grant              = st_q.fl_grant;
   assign o_fl_reject             = st_q.fl_reject;
   assign o_irq                   = st_q.irq;
   assign o_nmi                   = st_q.nmi;
   assign o_warm_rst              = st_q.warm;
   assign o_cold_rst              = st_q.cold;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_tm_after_erase: assert property (
      $rose(o_engineering_test_mode) |-> $past(o_flash_erase_req))
      else $error("test mode opened without flash erase");
   a_loader_tm_only: assert property (
      o_loader_en |-> (st_q.tm == TM_ACTIVE) && !o_flash_erase_req)
      else $error("loader enabled outside test mode");
   a_bad_key_refused: assert property (
      (st_q.tm == TM_IDLE) && !(wr_go && i_paddr == A_TM_KEY &&
      i_pwdata == TM_SECRET) |=> !o_flash_erase_req)
      else $error("test mode entry without secret");
   a_serial_guard: assert property (
      (st_q.tm != TM_ACTIVE) |=> $stable(st_q.serial))
      else $error("serial changed outside test mode");
   a_bridge_width: assert property (
      i_br_valid && i_br_size != 2'h2 |=> o_br_err && !o_br_done)
      else $error("narrow bridge access not refused");
   a_bridge_fetch: assert property (
      i_br_valid && i_br_fetch |=> o_br_err)
      else $error("bridge fetch not refused");
   a_flash_lock: assert property (
      i_fl_req && st_q.ctrl[C_LOCK] && i_fl_addr < LOCK_TOP
      |=> o_fl_reject && !o_fl_grant)
      else $error("locked flash access granted");
   a_status_held: assert property (
      st_q.status[EV_GLITCH] && !(wr_go && i_paddr == A_STATUS)
      |=> st_q.status[EV_GLITCH])
      else $error("violation flag lost");
   a_glitch_logged: assert property (
      i_glitch |=> st_q.status[EV_GLITCH])
      else $error("glitch not recorded");
   a_one_reaction: assert property (
      $onehot0({o_irq, o_nmi, o_warm_rst, o_cold_rst}))
      else $error("more than one reaction at once");
   a_pready_pulse: assert property (
      o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");

endmodule
`default_nettype wire

//--- src/svm_pkg.sv
package svm_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_STATUS  = 8'h04;
   localparam logic [7:0] A_REACT   = 8'h08;
   localparam logic [7:0] A_TM_KEY  = 8'h0c;
   localparam logic [7:0] A_TM_STAT = 8'h10;
   localparam logic [7:0] A_SERIAL  = 8'h14;
   localparam logic [7:0] A_PREPERS = 8'h18;
   localparam logic [7:0] A_CRC     = 8'h1c;
   localparam logic [7:0] A_CRC_INI = 8'h20;
   localparam logic [7:0] A_RG_BASE = 8'h40;
   localparam logic [7:0] A_RG_END  = 8'h7c;
   // control bits
   localparam int C_UAR  = 0;
   localparam int C_LOCK = 1;
   localparam int C_C16  = 2;
   // event indices in the status register
   localparam int EV_MIRROR = 0;
   localparam int EV_PARITY = 1;
   localparam int EV_BRIDGE = 2;
   localparam int EV_MPU    = 3;
   localparam int EV_FREQ   = 4;
   localparam int EV_GLITCH = 5;
   localparam int EV_LOCKUP = 6;
   localparam int EV_FLASH  = 7;
   localparam int N_EV      = 8;
   // reaction codes, higher is more severe
   localparam logic [2:0] RX_FLAG = 3'h0;
   localparam logic [2:0] RX_IRQ  = 3'h1;
   localparam logic [2:0] RX_NMI  = 3'h2;
   localparam logic [2:0] RX_WARM = 3'h3;
   localparam logic [2:0] RX_COLD = 3'h4;
   // region config fields
   localparam int R_EN   = 0;
   localparam int R_SZ   = 1;
   localparam int R_SRD  = 6;
   localparam int R_PW   = 14;
   localparam int R_UR   = 15;
   localparam int R_UW   = 16;
   localparam int R_XN   = 17;
   localparam int R_ATTR = 18;
   localparam int N_RG   = 8;
   // reset values and crc constants
   localparam logic [31:0] CRC_SEED = 32'hffff_ffff;
   localparam logic [31:0] P_CRC32  = 32'hedb8_8320;
   localparam logic [31:0] P_CRC16  = 32'h0000_a001;
   localparam logic [15:0] FREQ_SAT = 16'hffff;
   // test mode states, one-hot
   typedef enum logic [2:0] {
      TM_IDLE   = 3'b001,
      TM_ERASE  = 3'b010,
      TM_ACTIVE = 3'b100
   } svm_tm_type;
endpackage

//--- test/svm_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side: cpu bus master and flash controller
module svm_cpu_model #(
   parameter int DLY = 16
) (
   // clock
   input  wire logic        i_ref_clk,
   // flash erase handshake
   input  wire logic        i_erase_req,
   output logic             o_erase_done,
   // access requests
   output logic             o_br_valid,
   output logic [1:0]       o_br_size,
   output logic             o_mpu_valid,
   output logic             o_fl_req,
   output logic [31:0]      o_addr,
   output logic             o_write,
   output logic             o_user,
   output logic             o_fetch
);
   int cnt = 0;
   initial begin
      {o_erase_done, o_br_valid, o_mpu_valid, o_fl_req} = 4'h0;
      {o_br_size, o_addr, o_write, o_user, o_fetch} = '0;
   end
   // slow erase so the window before test mode opens is visible
   always @(posedge i_ref_clk) begin
      o_erase_done <= 1'b0;
      if (!i_erase_req)
         cnt <= 0;
      else if (cnt == DLY)
         o_erase_done <= 1'b1;
      else
         cnt <= cnt + 1;
   end
   // one access per call; fields inverted once the request is gone
   task automatic acc(input logic [2:0] k, input logic [1:0] sz,
                      input logic [31:0] a, input logic w, u, f);
      @(posedge i_ref_clk);
      {o_fl_req, o_mpu_valid, o_br_valid} <= k;
      {o_br_size, o_addr, o_write, o_user, o_fetch} <= {sz, a, w, u, f};
      @(posedge i_ref_clk);
      {o_fl_req, o_mpu_valid, o_br_valid} <= 3'h0;
      {o_br_size, o_addr, o_write, o_user, o_fetch} <= ~{sz, a, w, u, f};
   endtask
endmodule
`default_nettype wire

//--- test/test_security_violation_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module test_security_violation_monitor import svm_pkg::*;;
   localparam logic [31:0] KEY = 32'h1357_2468; // arbitrary value
   localparam logic [31:0] TOP = 32'h0000_1000;
   // bridge rows: size, fetch, user, user right bit, expected error
   localparam logic [5:0] BRT [6] = '{6'h20, 6'h03, 6'h13, 6'h2b,
                                      6'h25, 6'h26};
   // apb and reset
   logic        i_ref_clk = 1'b0, i_rst = 1'b1;
   logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, o_prdata, i_rd_data = 32'h0, addr, r;
   logic        o_pready, o_pslverr, e, i_flash_erase_done;
   logic        o_flash_erase_req, o_engineering_test_mode, o_loader_en;
   // detectors and responses
   logic [7:0]  i_mirror_a = 8'h00, i_mirror_b = 8'h00;
   logic [3:0]  ev = 4'h0, o_mpu_attr;
   logic        i_rd_par = 1'b0, o_br_done, o_br_err, o_mpu_fault;
   logic        o_fl_grant, o_fl_reject, o_irq, o_nmi, o_warm_rst, o_cold_rst;
   logic        br_v, mp_v, fl_v, w, u, f;
   logic [1:0]  br_s;
   wire         i_freq_tick = ev[0];
   wire         i_glitch = ev[1];
   wire         i_rd_valid = ev[2];
   wire         i_cpu_lockup = ev[3];
   int          mismatches = 0, compares = 0, n;

   svm_top #(.TM_SECRET(KEY), .LOCK_TOP(TOP), .FREQ_MIN(16'h0004)) dut (
      .i_ref_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_flash_erase_done,
      .o_flash_erase_req, .o_engineering_test_mode, .o_loader_en,
      .i_mirror_a, .i_mirror_b, .i_rd_valid, .i_rd_data, .i_rd_par,
      .i_freq_tick, .i_glitch, .i_cpu_lockup, .i_br_valid(br_v),
      .i_br_size(br_s), .i_br_fetch(f), .i_br_user(u), .o_br_done,
      .o_br_err, .i_mpu_valid(mp_v), .i_mpu_addr(addr), .i_mpu_write(w),
      .i_mpu_user(u), .i_mpu_fetch(f), .o_mpu_fault, .o_mpu_attr,
      .i_fl_req(fl_v), .i_fl_addr(addr), .o_fl_grant, .o_fl_reject,
      .o_irq, .o_nmi, .o_warm_rst, .o_cold_rst);
   svm_cpu_model m (
      .i_ref_clk, .i_erase_req(o_flash_erase_req),
      .o_erase_done(i_flash_erase_done), .o_br_valid(br_v),
      .o_br_size(br_s), .o_mpu_valid(mp_v), .o_fl_req(fl_v), .o_addr(addr),
      .o_write(w), .o_user(u), .o_fetch(f));

   always #20 i_ref_clk = ~i_ref_clk;

   task automatic chk(input string s, input logic [31:0] x, g);
      compares++;
      if (g !== x) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // apb transfer; answer taken at the edge that samples pready high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge i_ref_clk);
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, wr, a, d};
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      k = 0;
      // pready, data and error are sampled at the same rising edge
      do begin
         @(posedge i_ref_clk);
         k++;
      end while (o_pready !== 1'b1 && k < 16);
      if (o_pready !== 1'b1) begin
         chk("pready", 32'h1, 32'h0);
         end_sim();
      end
      r = o_prdata;
      e = o_pslverr;
      {i_psel, i_penable} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("read %h", a), x, r);
   endtask
   task automatic pl(input logic [3:0] v);
      @(posedge i_ref_clk);
      ev <= v;
      @(posedge i_ref_clk);
      ev <= 4'h0;
   endtask
   task automatic stat(input int b);
      rd(A_STATUS, 32'h1 << b);
      apb(1'b1, A_STATUS, 32'hff);
   endtask
   function automatic logic [31:0] crc(input logic [31:0] c,
                                       input logic [7:0]  b,
                                       input logic [31:0] p);
      c = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++)
         c = c[0] ? (c >> 1) ^ p : c >> 1;
      return c;
   endfunction
   function automatic logic [31:0] rx();
      return {28'h0, o_cold_rst, o_warm_rst, o_nmi, o_irq};
   endfunction

   // hang guard
   initial begin
      #4000000;
      chk("watchdog", 32'h0, 32'h1);
      end_sim();
   end
   initial begin
      repeat (15) @(posedge i_ref_clk);
      #1;
      chk("reset outs", 32'h0, {26'h0, o_cold_rst, o_warm_rst, o_nmi,
          o_irq, o_pready, o_loader_en});
      @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rd(A_STATUS, 32'h0);
      rd(A_CRC, CRC_SEED);
      rd(A_TM_STAT, 32'h1);
      // ordinary bridge cases from the table
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, A_CTRL, {31'h0, BRT[i][1]});
         m.acc(3'h1, BRT[i][5:4], 32'h0, 1'b0, BRT[i][2], BRT[i][3]);
         #1;
         chk("bridge", {30'h0, ~BRT[i][0], BRT[i][0]},
             {30'h0, o_br_done, o_br_err});
      end
      stat(EV_BRIDGE);
      // detectors
      @(posedge i_ref_clk);
      i_mirror_b <= 8'h01;
      @(posedge i_ref_clk);
      i_mirror_b <= 8'h00;
      stat(EV_MIRROR);
      {i_rd_data, i_rd_par} <= 33'h3;
      pl(4'h4);
      rd(A_STATUS, 32'h0);
      i_rd_par <= 1'b0;
      pl(4'h4);
      stat(EV_PARITY);
      pl(4'h1);
      repeat (8) @(posedge i_ref_clk);
      pl(4'h1);
      rd(A_STATUS, 32'h0);
      pl(4'h1);
      pl(4'h1);
      stat(EV_FREQ);
      pl(4'h8);
      stat(EV_LOCKUP);
      // every reaction code on the glitch event, 5 acts as flag
      for (int k = 0; k < 6; k++) begin
         apb(1'b1, A_REACT, 32'(k) << 15);
         pl(4'h2);
         #1;
         chk("reaction", (k > 0 && k < 5) ? 32'h1 << (k - 1) : 32'h0,
             rx());
      end
      rd(A_STATUS, 32'h20);
      apb(1'b1, A_REACT, (32'h3 << 15) | (32'h4 << 18));
      pl(4'ha);
      #1;
      chk("strongest", 32'h8, rx());
      rd(A_STATUS, 32'h60);
      apb(1'b1, A_STATUS, 32'hff);
      // regions 0 and 7 overlapping, sub-region disable on 7
      apb(1'b1, A_RG_BASE, 32'h0);
      apb(1'b1, A_RG_BASE + 8'h04, 32'h11);
      m.acc(3'h2, 2'h2, 32'h10, 1'b0, 1'b1, 1'b0);
      #1;
      chk("mpu user", 32'h10, {27'h0, o_mpu_fault, o_mpu_attr});
      m.acc(3'h2, 2'h2, 32'h10, 1'b0, 1'b0, 1'b0);
      #1;
      chk("mpu priv", 32'h0, {27'h0, o_mpu_fault, o_mpu_attr});
      apb(1'b1, A_RG_END - 8'h04, 32'h0);
      apb(1'b1, A_RG_END, 32'h148011);
      m.acc(3'h2, 2'h2, 32'h10, 1'b0, 1'b1, 1'b0);
      #1;
      chk("mpu overlap", 32'h05,
          {27'h0, o_mpu_fault, o_mpu_attr});
      apb(1'b1, A_RG_END, 32'h148051);
      m.acc(3'h2, 2'h2, 32'h10, 1'b0, 1'b1, 1'b0);
      #1;
      chk("mpu subregion", 32'h10,
          {27'h0, o_mpu_fault, o_mpu_attr});
      stat(EV_MPU);
      // flash lock at the boundary
      apb(1'b1, A_CTRL, 32'h2);
      m.acc(3'h4, 2'h2, TOP - 32'h1, 1'b1, 1'b0, 1'b0);
      #1;
      chk("flash low", 32'h1, {30'h0, o_fl_grant, o_fl_reject});
      m.acc(3'h4, 2'h2, TOP, 1'b1, 1'b0, 1'b0);
      #1;
      chk("flash top", 32'h2, {30'h0, o_fl_grant, o_fl_reject});
      stat(EV_FLASH);
      // crc32 over two bytes, then crc16
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_CRC_INI, 32'h0);
      apb(1'b1, A_CRC, 32'h31);
      apb(1'b1, A_CRC, 32'h32);
      rd(A_CRC, crc(crc(CRC_SEED, 8'h31, P_CRC32), 8'h32, P_CRC32));
      apb(1'b1, A_CTRL, 32'h4);
      apb(1'b1, A_CRC_INI, 32'h0);
      apb(1'b1, A_CRC, 32'h31);
      rd(A_CRC, crc(32'hffff, 8'h31, P_CRC16));
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      // test mode entry
      chk("loader idle", 32'h0, {31'h0, o_loader_en});
      apb(1'b1, A_SERIAL, 32'h1234);
      chk("serial err", 32'h1, {31'h0, e});
      apb(1'b1, A_TM_KEY, KEY ^ 32'h1);
      rd(A_TM_STAT, 32'h1);
      apb(1'b1, A_TM_KEY, KEY);
      @(posedge i_ref_clk);
      #1;
      chk("erase", 32'h4, {29'h0, o_flash_erase_req,
          o_engineering_test_mode, o_loader_en});
      rd(A_TM_STAT, 32'h2);
      apb(1'b1, A_PREPERS, 32'h55);
      chk("early write err", 32'h1, {31'h0, e});
      n = 0;
      while (o_engineering_test_mode !== 1'b1 && n < 64) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      chk("active", 32'h3, {29'h0, o_flash_erase_req,
          o_engineering_test_mode, o_loader_en});
      apb(1'b1, A_SERIAL, 32'h1234);
      chk("serial ok", 32'h0, {31'h0, e});
      // reset in mid-run closes test mode
      i_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      #1;
      chk("after reset", 32'h0,
          {30'h0, o_engineering_test_mode, o_loader_en});
      rd(A_TM_STAT, 32'h1);
      end_sim();
   end
endmodule
`default_nettype wire
